// ===== logic/fault_pkg.sv
package fault_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0]  CONTROL_OFFSET  = 8'h00;
   localparam logic [7:0]  UNDERVOLTAGE_LOCKOUT_CFG_OFFSET = 8'h04;
   localparam logic [7:0]  STATUS_OFFSET   = 8'h08;
   localparam logic [7:0]  EVENT_OFFSET    = 8'h0C;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int          SOFT_RESET_POS   = 0;
   localparam int          ENABLE_LSB       = 4;
   localparam int          UNDERVOLTAGE_LOCKOUT_CODE_LSB    = 0;
   localparam int          EVENT_LSB        = 0;
   localparam int          STAT_STATE_LSB   = 0;
   localparam int          STAT_PHASE_LSB   = 4;
   localparam int          STAT_SHDN_POS    = 8;
   localparam int          STAT_UNDERVOLTAGE_LOCKOUT_POS    = 9;
   localparam int          STAT_IO_GOOD_POS = 10;
   localparam int          STAT_THERM_POS   = 11;
   localparam int          STAT_CE_POS      = 12;
   localparam int          STAT_LATCHED_POS = 13;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [3:0]  UNDERVOLTAGE_LOCKOUT_CODE_RST = 4'h8;
   localparam logic [3:0]  ENABLE_RST    = 4'h0;
   localparam logic [1:0]  EVENT_RST     = 2'h0;
   localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Enumerations
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_LOAD     = 2'b00,
      ST_SHUTDOWN = 2'b01,
      ST_ACTIVE   = 2'b10,
      ST_THERMAL  = 2'b11
   } power_state_e;

   typedef enum logic [2:0] {
      PH_FOUR        = 3'b000,
      PH_THREE_ONE   = 3'b001,
      PH_TWO_TWO     = 3'b010,
      PH_TWO_ONE_ONE = 3'b011,
      PH_SINGLES     = 3'b100
   } phase_mode_e;

endpackage

// ===== logic/phase_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none

interface phase_cfg_if;
   import fault_pkg::*;
   logic        latched;
   logic [2:0]  select;
   phase_mode_e mode;

   modport source (output latched, output select, output mode);
   modport sink   (input latched, input select, input mode);
endinterface

`default_nettype wire

// ===== logic/phase_cfg_latch.sv
`timescale 1ns/1ps
`default_nettype none

module phase_cfg_latch
   import fault_pkg::*;
(
   // Clock and reset
   input  wire logic   clk_in,
   input  wire logic   rst_in,
   // Strap pins
   input  wire logic   phase_select_bit0_in,
   input  wire logic   phase_select_bit1_in,
   input  wire logic   phase_select_bit2_in,
   // Latched result
   phase_cfg_if.source cfg
);

   typedef struct packed {
      logic        latched;
      logic [2:0]  select;
      phase_mode_e mode;
   } latch_s;

   latch_s s_reg;
   latch_s s_next;

   function automatic phase_mode_e decode_phase(input logic [2:0] sel);
      phase_mode_e m;
      m = PH_SINGLES;
      if (!sel[2]) begin
         case (sel[1:0])
            2'b00:   m = PH_FOUR;
            2'b01:   m = PH_THREE_ONE;
            2'b10:   m = PH_TWO_TWO;
            default: m = PH_TWO_ONE_ONE;
         endcase
      end
      return m;
   endfunction

   always_comb begin
      s_next = s_reg;
      if (!s_reg.latched) begin
         s_next.latched = 1'b1;
         s_next.select  = {phase_select_bit2_in, phase_select_bit1_in, phase_select_bit0_in};
         s_next.mode    = decode_phase(s_next.select);
      end
   end

   // Straps are caught by the first clocked edge after release, not by the reset itself
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_reg <= '{latched: 1'b0, select: 3'b000, mode: PH_FOUR};
      end else begin
         s_reg <= s_next;
      end
   end

   assign cfg.latched = s_reg.latched;
   assign cfg.select  = s_reg.select;
   assign cfg.mode    = s_reg.mode;

endmodule

`default_nettype wire

// ===== logic/fault_reset_and_phase_latch.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Phase selects sampled once after power-on reset, then held until next reset.
// - Selects decode: 000 four, 001 3+1, 010 2+2, 011 2+1+1, 1xx singles.
// - Undervoltage forces shutdown; leave only once supply is back above rising level.
// - Loss of IO supply good forces shutdown until it returns.
// - Thermal trip starts soft-stop of outputs and resets off-class registers.
// - Register bus keeps working during thermal shutdown.
// - Thermal state ends when recovery indication shows the hysteresis drop.
// - Each of the two warning comparators sets its own event flag.
// - After power-up the block sits in shutdown until chip enable goes high.
// - On power-up the block loads register defaults from one-time storage.
// - Power-on reset returns supply-class registers to defaults.
// - Any shutdown or power-off returns off-class registers to defaults.
// - Writing one to soft reset resets off-class registers; bit self-clears.
// - Chip enable low: shutdown, all regulators off, off-class registers reset.
// - Undervoltage and IO faults are immediate shutdowns resetting off-class registers.
module fault_reset_and_phase_latch
   import fault_pkg::*;
(
   // Clock and power-on reset
   input  wire logic        CLK_IN,
   input  wire logic        RST_IN,
   // AHB-Lite slave
   input  wire logic        HSEL_IN,
   input  wire logic [31:0] HADDR_IN,
   input  wire logic [1:0]  HTRANS_IN,
   input  wire logic        HWRITE_IN,
   input  wire logic [2:0]  HSIZE_IN,
   input  wire logic [31:0] HWDATA_IN,
   input  wire logic        HREADY_IN,
   output logic [31:0]      HRDATA_OUT,
   output logic             HREADYOUT_OUT,
   output logic             HRESP_OUT,
   // Supply and temperature monitors
   input  wire logic        SYS_UNDERVOLTAGE_IN,
   input  wire logic        IO_SUPPLY_GOOD_IN,
   input  wire logic        THERMAL_TRIP_IN,
   input  wire logic        THERMAL_RECOVER_IN,
   input  wire logic [1:0]  THERMAL_WARN_IN,
   input  wire logic        CHIP_ENABLE_IN,
   // One-time storage defaults and strap pins
   input  wire logic [3:0]  OTP_ENABLE_DEFAULT_IN,
   input  wire logic        PHASE_SELECT_BIT0_IN,
   input  wire logic        PHASE_SELECT_BIT1_IN,
   input  wire logic        PHASE_SELECT_BIT2_IN,
   // Control outputs
   output logic             SHUTDOWN_OUT,
   output logic             SOFT_STOP_OUT,
   output logic             OFF_RESET_OUT,
   output logic [3:0]       REGULATOR_ENABLE_OUT,
   output logic [3:0]       UNDERVOLTAGE_LOCKOUT_FALL_CODE_OUT,
   output logic [2:0]       PHASE_MODE_OUT,
   output logic [1:0]       THERMAL_WARN_EVENT_OUT
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      power_state_e state;
      logic         wr_pend;
      logic         wr_valid;
      logic [7:0]   wr_addr;
      logic [31:0]  rdata;
      logic         ready;
      logic [3:0]   enables;
      logic         soft_reset;
      logic [3:0]   undervoltage_lockout_code;
      logic [3:0]   otp_default;
      logic [1:0]   events;
      logic [1:0]   warn_prev;
      logic         shutdown;
      logic         soft_stop;
      logic         off_reset;
      logic [3:0]   reg_enable;
      logic [2:0]   phase_mode;
   } ctrl_s;

   localparam ctrl_s CTRL_RST = '{
      state:       ST_LOAD,
      wr_pend:     1'b0,
      wr_valid:    1'b0,
      wr_addr:     8'h00,
      rdata:       RDATA_RST,
      ready:       1'b1,
      enables:     ENABLE_RST,
      soft_reset:  1'b0,
      undervoltage_lockout_code:   UNDERVOLTAGE_LOCKOUT_CODE_RST,
      otp_default: ENABLE_RST,
      events:      EVENT_RST,
      warn_prev:   2'b00,
      shutdown:    1'b1,
      soft_stop:   1'b0,
      off_reset:   1'b1,
      reg_enable:  4'h0,
      phase_mode:  3'b000
   };

   ctrl_s s_reg;
   ctrl_s s_next;

   phase_cfg_if phase_cfg ();

   phase_cfg_latch u_phase_cfg_latch (
      .clk_in               (CLK_IN),
      .rst_in               (RST_IN),
      .phase_select_bit0_in (PHASE_SELECT_BIT0_IN),
      .phase_select_bit1_in (PHASE_SELECT_BIT1_IN),
      .phase_select_bit2_in (PHASE_SELECT_BIT2_IN),
      .cfg                  (phase_cfg.source)
   );

   // ---------------------------------------------------------------
   // Register read mux
   // ---------------------------------------------------------------
   function automatic logic [31:0] read_word(input ctrl_s c, input logic [7:0] addr,
                                             input logic [2:0] mode, input logic latched,
                                             input logic req, input logic [3:0] raw);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (addr)
         CONTROL_OFFSET:  w[ENABLE_LSB +: 4] = c.enables;
         UNDERVOLTAGE_LOCKOUT_CFG_OFFSET: w[UNDERVOLTAGE_LOCKOUT_CODE_LSB +: 4] = c.undervoltage_lockout_code;
         STATUS_OFFSET: begin
            w[STAT_STATE_LSB +: 2] = c.state;
            w[STAT_PHASE_LSB +: 3] = mode;
            w[STAT_SHDN_POS]       = req;
            w[STAT_UNDERVOLTAGE_LOCKOUT_POS]       = raw[0];
            w[STAT_IO_GOOD_POS]    = raw[1];
            w[STAT_THERM_POS]      = raw[2];
            w[STAT_CE_POS]         = raw[3];
            w[STAT_LATCHED_POS]    = latched;
         end
         EVENT_OFFSET:    w[EVENT_LSB +: 2] = c.events;
         default:         w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   logic       shutdown_req;
   logic       supply_fault;
   logic       off_reset;
   logic [1:0] warn_rise;
   logic       addr_ok;

   always_comb begin
      s_next    = s_reg;
      off_reset = 1'b0;
      supply_fault = SYS_UNDERVOLTAGE_IN | ~IO_SUPPLY_GOOD_IN | ~CHIP_ENABLE_IN;
      shutdown_req = supply_fault | THERMAL_TRIP_IN;
      warn_rise    = THERMAL_WARN_IN & ~s_reg.warn_prev;
      addr_ok      = HADDR_IN[31:8] == 24'h00_0000;
      s_next.warn_prev = THERMAL_WARN_IN;
      s_next.wr_pend   = 1'b0;

      // Data phase of a write taken on the previous edge
      if (s_reg.wr_pend && s_reg.wr_valid) begin
         case (s_reg.wr_addr)
            CONTROL_OFFSET: begin
               s_next.enables = HWDATA_IN[ENABLE_LSB +: 4];
               if (HWDATA_IN[SOFT_RESET_POS]) begin
                  s_next.soft_reset = 1'b1;
               end
            end
            UNDERVOLTAGE_LOCKOUT_CFG_OFFSET: s_next.undervoltage_lockout_code = HWDATA_IN[UNDERVOLTAGE_LOCKOUT_CODE_LSB +: 4];
            EVENT_OFFSET:    s_next.events = s_reg.events & ~HWDATA_IN[EVENT_LSB +: 2];
            default:         s_next.events = s_reg.events;
         endcase
      end

      // soft reset held one cycle, off-class only
      if (s_reg.soft_reset) begin
         s_next.soft_reset = 1'b0;
         off_reset         = 1'b1;
      end

      case (s_reg.state)
         ST_LOAD: begin
            s_next.otp_default = OTP_ENABLE_DEFAULT_IN;
            s_next.state       = ST_SHUTDOWN;
            off_reset          = 1'b1;
         end
         // stay dormant until enable and supplies are good and no thermal trip
         ST_SHUTDOWN: begin
            off_reset = 1'b1;
            if (!shutdown_req) begin
               s_next.state = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (supply_fault) begin
               s_next.state = ST_SHUTDOWN;
               off_reset    = 1'b1;
            end else if (THERMAL_TRIP_IN) begin
               s_next.state = ST_THERMAL;
               off_reset    = 1'b1;
            end
         end
         ST_THERMAL: begin
            if (supply_fault) begin
               s_next.state = ST_SHUTDOWN;
               off_reset    = 1'b1;
            end else if (THERMAL_RECOVER_IN && !THERMAL_TRIP_IN) begin
               s_next.state = ST_ACTIVE;
            end
         end
         default: s_next.state = ST_SHUTDOWN;
      endcase

      if (off_reset) begin
         s_next.enables    = (s_reg.state == ST_LOAD) ? OTP_ENABLE_DEFAULT_IN : s_reg.otp_default;
         s_next.soft_reset = 1'b0;
      end

      // a warning edge sets its flag, winning over a clear
      s_next.events = s_next.events | warn_rise;

      s_next.rdata = RDATA_RST;
      if (HSEL_IN && HREADY_IN && HTRANS_IN[1]) begin
         if (HWRITE_IN) begin
            s_next.wr_pend  = 1'b1;
            s_next.wr_valid = addr_ok;
            s_next.wr_addr  = HADDR_IN[7:0];
         end else if (addr_ok) begin
            s_next.rdata = read_word(s_next, HADDR_IN[7:0], phase_cfg.mode,
                                     phase_cfg.latched, shutdown_req,
                                     {CHIP_ENABLE_IN, THERMAL_TRIP_IN,
                                      IO_SUPPLY_GOOD_IN, SYS_UNDERVOLTAGE_IN});
         end
      end
      s_next.ready = 1'b1;

      // regulators off outside the active state
      s_next.reg_enable = (s_next.state == ST_ACTIVE) ? s_next.enables : 4'h0;
      s_next.soft_stop  = s_next.state == ST_THERMAL;
      s_next.shutdown   = shutdown_req;
      s_next.off_reset  = off_reset;
      s_next.phase_mode = phase_cfg.mode;
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         s_reg <= CTRL_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign HRDATA_OUT             = s_reg.rdata;
   assign HREADYOUT_OUT          = s_reg.ready;
   assign HRESP_OUT              = 1'b0;
   assign SHUTDOWN_OUT           = s_reg.shutdown;
   assign SOFT_STOP_OUT          = s_reg.soft_stop;
   assign OFF_RESET_OUT          = s_reg.off_reset;
   assign REGULATOR_ENABLE_OUT   = s_reg.reg_enable;
   assign UNDERVOLTAGE_LOCKOUT_FALL_CODE_OUT     = s_reg.undervoltage_lockout_code;
   assign PHASE_MODE_OUT         = s_reg.phase_mode;
   assign THERMAL_WARN_EVENT_OUT = s_reg.events;

endmodule

`default_nettype wire

// ===== test/fault_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fault_chk
   import fault_pkg::*;
(
   // Clock and reset
   input wire logic        CLK_IN,
   input wire logic        RST_IN,
   // Bus
   input wire logic        HSEL_IN,
   input wire logic [1:0]  HTRANS_IN,
   input wire logic        HWRITE_IN,
   input wire logic        HREADY_IN,
   input wire logic [31:0] HRDATA_OUT,
   input wire logic        HREADYOUT_OUT,
   input wire logic        HRESP_OUT,
   // Monitors
   input wire logic        SYS_UNDERVOLTAGE_IN,
   input wire logic        IO_SUPPLY_GOOD_IN,
   input wire logic        THERMAL_TRIP_IN,
   input wire logic [1:0]  THERMAL_WARN_IN,
   input wire logic        CHIP_ENABLE_IN,
   // Control outputs
   input wire logic        SHUTDOWN_OUT,
   input wire logic        SOFT_STOP_OUT,
   input wire logic        OFF_RESET_OUT,
   input wire logic [3:0]  REGULATOR_ENABLE_OUT,
   input wire logic [3:0]  UNDERVOLTAGE_LOCKOUT_FALL_CODE_OUT,
   input wire logic [2:0]  PHASE_MODE_OUT,
   input wire logic [1:0]  THERMAL_WARN_EVENT_OUT
);
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);

   a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
      else $error("bus answer not ready or not okay");
   a_rdata_idle: assert property (
      !(HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN) |=> HRDATA_OUT == 32'h0000_0000)
      else $error("read data outside a read");
   a_uv_shutdown: assert property (
      SYS_UNDERVOLTAGE_IN |-> ##1 SHUTDOWN_OUT) else $error("undervoltage not shut down");
   a_io_shutdown: assert property (
      !IO_SUPPLY_GOOD_IN |-> ##1 SHUTDOWN_OUT) else $error("io loss not shut down");
   a_shdn_cause: assert property (
      !$past(RST_IN) && SHUTDOWN_OUT |-> $past(SYS_UNDERVOLTAGE_IN) || !$past(IO_SUPPLY_GOOD_IN)
      || $past(THERMAL_TRIP_IN) || !$past(CHIP_ENABLE_IN)) else $error("shutdown without cause");
   a_ce_off: assert property (
      !$past(RST_IN) && !CHIP_ENABLE_IN |-> ##1 REGULATOR_ENABLE_OUT == 4'h0 && OFF_RESET_OUT)
      else $error("chip enable low did not turn off");
   a_trip_soft: assert property (
      $rose(SOFT_STOP_OUT) |-> $past(THERMAL_TRIP_IN)) else $error("soft stop without trip");
   a_thermal_off: assert property (
      SOFT_STOP_OUT |-> REGULATOR_ENABLE_OUT == 4'h0) else $error("enables on in thermal");
   a_phase_held: assert property (
      !$past(RST_IN, 1) && !$past(RST_IN, 2) && !$past(RST_IN, 3) && !$past(RST_IN, 4)
      |-> $stable(PHASE_MODE_OUT)) else $error("phase mode changed");
   a_reset_dflt: assert property (disable iff (1'b0)
      RST_IN |=> UNDERVOLTAGE_LOCKOUT_FALL_CODE_OUT == UNDERVOLTAGE_LOCKOUT_CODE_RST && THERMAL_WARN_EVENT_OUT == EVENT_RST)
      else $error("reset defaults wrong");
   a_warn_low: assert property (
      $rose(THERMAL_WARN_IN[0]) |-> ##[1:2] THERMAL_WARN_EVENT_OUT[0]) else $error("warn0 lost");
   a_warn_high: assert property (
      $rose(THERMAL_WARN_IN[1]) |-> ##[1:2] THERMAL_WARN_EVENT_OUT[1]) else $error("warn1 lost");
endmodule

bind fault_reset_and_phase_latch fault_chk u_chk (.CLK_IN, .RST_IN, .HSEL_IN, .HTRANS_IN,
   .HWRITE_IN, .HREADY_IN, .HRDATA_OUT, .HREADYOUT_OUT, .HRESP_OUT, .SYS_UNDERVOLTAGE_IN,
   .IO_SUPPLY_GOOD_IN, .THERMAL_TRIP_IN, .THERMAL_WARN_IN, .CHIP_ENABLE_IN, .SHUTDOWN_OUT,
   .SOFT_STOP_OUT, .OFF_RESET_OUT, .REGULATOR_ENABLE_OUT, .UNDERVOLTAGE_LOCKOUT_FALL_CODE_OUT,
   .PHASE_MODE_OUT, .THERMAL_WARN_EVENT_OUT);
`default_nettype wire

// ===== test/ahb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model
   import fault_pkg::*;
(
   // Clock and slave answer
   input  wire logic        clk_in,
   input  wire logic        hready_in,
   input  wire logic [31:0] hrdata_in,
   // Master request
   output logic             hsel_out,
   output logic [31:0]      haddr_out,
   output logic [1:0]       htrans_out,
   output logic             hwrite_out,
   output logic [2:0]       hsize_out,
   output logic [31:0]      hwdata_out
);
   initial begin
      hsel_out   = 1'b0;
      haddr_out  = 32'h0000_0000;
      htrans_out = 2'b00;
      hwrite_out = 1'b0;
      hsize_out  = 3'b010;
      hwdata_out = 32'h0000_0000;
   end
   // Call just after a rising edge; request stands until hready is seen high
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel_out   <= 1'b1;
      haddr_out  <= a;
      htrans_out <= 2'b10;
      hwrite_out <= wr;
      do @(posedge clk_in); while (hready_in !== 1'b1);
      hsel_out   <= 1'b0;
      htrans_out <= 2'b00;
      hwdata_out <= wd;
      do @(posedge clk_in); while (hready_in !== 1'b1);
      rd = hrdata_in;
      // Released data line must not keep showing the written word
      hwdata_out <= ~wd;
   endtask
   task automatic soft_reset(input logic [3:0] en);
      logic [31:0] r;
      xfer(1'b1, {24'h0, CONTROL_OFFSET}, {24'h0, en, 4'h1}, r);
   endtask
endmodule
`default_nettype wire

// ===== test/fault_reset_and_phase_latch_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fault_reset_and_phase_latch_tb
   import fault_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, uv = 1'b0, iog = 1'b1, trip = 1'b0, recov = 1'b0;
   logic        ce = 1'b0, hsel, hwrite, hready, hresp, shdn, sstop, offr;
   logic [1:0]  warn = 2'b00, htrans, wevt;
   logic [2:0]  straps = 3'b000, hsize, phase;
   logic [3:0]  otp = 4'h0, reg_en, undervoltage_lockout;
   logic [31:0] haddr, hwdata, hrdata, r;
   int          fail_count = 0, n_tests = 0;
   integer      seed = 32'h8ce8_99d0;

   always #4 clk = ~clk;

   ahb_host_model u_host (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata),
      .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
      .hsize_out(hsize), .hwdata_out(hwdata));

   fault_reset_and_phase_latch dut (.CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel),
      .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
      .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
      .HRESP_OUT(hresp), .SYS_UNDERVOLTAGE_IN(uv), .IO_SUPPLY_GOOD_IN(iog),
      .THERMAL_TRIP_IN(trip), .THERMAL_RECOVER_IN(recov), .THERMAL_WARN_IN(warn),
      .CHIP_ENABLE_IN(ce), .OTP_ENABLE_DEFAULT_IN(otp), .PHASE_SELECT_BIT0_IN(straps[0]),
      .PHASE_SELECT_BIT1_IN(straps[1]), .PHASE_SELECT_BIT2_IN(straps[2]), .SHUTDOWN_OUT(shdn),
      .SOFT_STOP_OUT(sstop), .OFF_RESET_OUT(offr), .REGULATOR_ENABLE_OUT(reg_en),
      .UNDERVOLTAGE_LOCKOUT_FALL_CODE_OUT(undervoltage_lockout), .PHASE_MODE_OUT(phase), .THERMAL_WARN_EVENT_OUT(wevt));

   function automatic logic [2:0] mode_of(input logic [2:0] s);
      return s[2] ? PH_SINGLES : {1'b0, s[1:0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      u_host.xfer(1'b1, {24'h0, a}, d, x);
   endtask
   task automatic rd(input logic [7:0] a);
      u_host.xfer(1'b0, {24'h0, a}, 32'h0, r);
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      settle(6);
   endtask
   task automatic fault(input int k, input logic on);
      case (k)
         0: uv <= on;
         1: iog <= !on;
         2: begin
            trip  <= on;
            recov <= !on;
         end
         default: ce <= !on;
      endcase
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      conclude();
   end

   initial begin
      logic [3:0] c, e;
      otp <= 4'($random(seed));
      do_reset();
      chk(shdn, 1'b1, "idle shutdown");
      chk(reg_en, 4'h0, "idle enables");
      ce <= 1'b1;
      settle(4);
      rd(STATUS_OFFSET);
      chk(r[1:0], 2'b10, "state active");
      chk(r >> STAT_SHDN_POS, 32'h0000_0034, "status levels");
      chk(reg_en, otp, "otp default");
      c = 4'($random(seed)) & 4'h7;
      wr(UNDERVOLTAGE_LOCKOUT_CFG_OFFSET, {28'h0, c});
      settle(1);
      chk(undervoltage_lockout, c, "fall code");
      $display("test bring-up done");
      for (int k = 0; k < 4; k++) begin
         e = ~otp;
         wr(CONTROL_OFFSET, {24'h0, e, 4'h0});
         settle(2);
         chk(reg_en, e, "enables written");
         fault(k, 1'b1);
         settle(3);
         chk(shdn, 1'b1, "shutdown on fault");
         chk(reg_en, 4'h0, "regulators off");
         if (k == 2) begin
            chk(sstop, 1'b1, "soft stop");
            c = 4'($random(seed)) & 4'h7;
            wr(UNDERVOLTAGE_LOCKOUT_CFG_OFFSET, {28'h0, c});
            rd(UNDERVOLTAGE_LOCKOUT_CFG_OFFSET);
            chk(r, {28'h0, c}, "bus in thermal");
            trip <= 1'b0;
            settle(3);
            chk(sstop, 1'b1, "held without recovery");
         end
         fault(k, 1'b0);
         settle(4);
         chk(shdn, 1'b0, "leave shutdown");
         chk(sstop, 1'b0, "thermal recovered");
         chk(reg_en, otp, "off-class default");
      end
      chk(undervoltage_lockout, c, "supply class kept");
      $display("test faults done");
      wr(CONTROL_OFFSET, {24'h0, ~otp, 4'h0});
      u_host.soft_reset(otp ^ 4'h5);
      settle(1);
      chk(offr, 1'b1, "off reset pulse");
      settle(2);
      chk(offr, 1'b0, "off reset one cycle");
      chk(reg_en, otp, "soft reset enables");
      rd(CONTROL_OFFSET);
      chk(r, {24'h0, otp, 4'h0}, "soft bit cleared");
      chk(undervoltage_lockout, c, "soft spares code");
      chk(phase, 3'b000, "soft spares phase");
      $display("test soft reset done");
      for (int i = 0; i < 2; i++) begin
         warn[i] <= 1'b1;
         settle(3);
         rd(EVENT_OFFSET);
         chk(r, 32'(1) << i, "warning event");
         warn[i] <= 1'b0;
         wr(EVENT_OFFSET, 32'(1) << i);
         settle(2);
         chk(wevt, 2'b00, "event cleared");
      end
      wr(8'h40, 32'($random(seed)));
      rd(8'h40);
      chk(r, 32'h0000_0000, "unmapped read");
      $display("test events done");
      for (int s = 0; s < 8; s++) begin
         straps <= 3'(s);
         do_reset();
         chk(phase, mode_of(3'(s)), "phase decode");
         chk(undervoltage_lockout, UNDERVOLTAGE_LOCKOUT_CODE_RST, "supply reset");
         straps <= ~3'(s);
         settle(3);
         chk(phase, mode_of(3'(s)), "phase held");
      end
      $display("test straps done");
      conclude();
   end
endmodule
`default_nettype wire
